/* verilog/rtc_i2c_host.v */
// two-wire bus master that reads and writes the clock chip's registers
// assumes open-drain pins resolved outside; pin inputs are asynchronous
`timescale 1ns/1ps
`include "rtc_host_consts.vh"
module rtc_i2c_host #(
   parameter CLK_DIV   = `CLK_HZ / (`SCL_HZ * 4),
   parameter LIMIT_CYC = `XFER_LIMIT_CYC,
   parameter FIFO_DEP  = 16
) (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst_b,
   // command: mode 0 write, 1 pointed read, 2 continued read
   input  wire       cmd_valid,
   output wire       cmd_ready,
   input  wire [1:0] cmd_mode,
   input  wire [7:0] cmd_ptr,
   input  wire [7:0] cmd_len,
   // write data stream
   input  wire       wr_valid,
   output wire       wr_ready,
   input  wire [7:0] wr_data,
   // read data stream
   output wire       rd_valid,
   input  wire       rd_ready,
   output wire [7:0] rd_data,
   // status
   output reg        busy_r,
   output reg        nack_err_r,
   output reg        timeout_r,
   // bus pins
   input  wire       scl_in,
   output wire       scl_out,
   output wire       scl_oe,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe
);
   // ------------------------------------------------------------
   // states and quarter-bit tick
   // ------------------------------------------------------------
   localparam S_IDLE = 4'd0, S_START = 4'd1, S_BIT = 4'd2, S_ACK = 4'd3;
   localparam S_NEXT = 4'd4, S_RSTART = 4'd5, S_STOP = 4'd6;
   localparam S_FETCH = 4'd7;

   reg [3:0]  st_r;
   reg [15:0] div_r;
   reg [1:0]  ph_r;
   reg [2:0]  bit_r;
   reg [7:0]  sh_r;
   reg [7:0]  left_r;
   reg [1:0]  mode_r;
   reg [7:0]  ptr_r;
   reg [1:0]  stage_r;   // 0 addr, 1 pointer, 2 data
   reg        dir_r;
   reg        scl_lo_r;
   reg        sda_lo_r;
   reg [31:0] tmo_r;
   reg        scl_m_r, scl_s_r, sda_m_r, sda_s_r;
   reg        rd_push_r;
   reg [7:0]  rd_byte_r;
   wire       tick;
   wire       rdf_ready;
   wire       stretch;

   always @(posedge clk_sys) begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
   end

   // hold the bit clock while a slave stretches scl low
   assign stretch = !scl_lo_r && !scl_s_r;
   assign tick    = (div_r == CLK_DIV[15:0] - 16'd1) && !stretch;

   always @(posedge clk_sys) begin
      if (!rst_b || st_r == S_IDLE || tick) begin
         div_r <= 16'd0;
      end else if (!stretch) begin
         div_r <= div_r + 16'd1;
      end
   end

   // open-drain: only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_lo_r;
   assign sda_oe  = sda_lo_r;

   assign cmd_ready = (st_r == S_IDLE);
   assign wr_ready  = (st_r == S_FETCH) && (stage_r == 2'd2) && !dir_r && (left_r != 8'd0);

   // ------------------------------------------------------------
   // read data fifo
   // ------------------------------------------------------------
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEP), .AW(4)) u_rdf (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (rd_push_r),
      .in_ready  (rdf_ready),
      .in_data   (rd_byte_r),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data),
      .flush     (1'b0)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         st_r <= S_IDLE; ph_r <= 2'd0; bit_r <= 3'd0; sh_r <= 8'h00;
         left_r <= 8'h00; mode_r <= 2'd0; ptr_r <= 8'h00; stage_r <= 2'd0;
         dir_r <= 1'b0; scl_lo_r <= 1'b0; sda_lo_r <= 1'b0; tmo_r <= 32'd0;
         busy_r <= 1'b0; nack_err_r <= 1'b0; timeout_r <= 1'b0;
         rd_push_r <= 1'b0; rd_byte_r <= 8'h00;
      end else begin
         rd_push_r <= 1'b0;
         if (st_r != S_IDLE) begin
            tmo_r <= tmo_r + 32'd1;
         end
         case (st_r)
         S_IDLE: begin
            scl_lo_r <= 1'b0;
            sda_lo_r <= 1'b0;
            busy_r   <= 1'b0;
            tmo_r    <= 32'd0;
            ph_r     <= 2'd0;
            if (cmd_valid) begin
               mode_r <= cmd_mode; ptr_r <= cmd_ptr; left_r <= cmd_len;
               busy_r <= 1'b1; nack_err_r <= 1'b0; timeout_r <= 1'b0;
               stage_r <= 2'd0;
               dir_r <= (cmd_mode == 2'd2) ? `DIR_READ : `DIR_WRITE;
               st_r <= S_START;
            end
         end
         S_START, S_RSTART: if (tick) begin
            // sda falls while scl is high
            ph_r <= ph_r + 2'd1;
            case (ph_r)
            2'd0: begin scl_lo_r <= (st_r == S_RSTART); sda_lo_r <= 1'b0; end
            2'd1: scl_lo_r <= 1'b0;
            2'd2: sda_lo_r <= 1'b1;
            default: begin
               scl_lo_r <= 1'b1;
               sh_r  <= {`SLAVE_ADDR, dir_r};
               bit_r <= 3'd7;
               stage_r <= 2'd0;
               st_r <= S_BIT;
            end
            endcase
         end
         S_BIT: if (tick) begin
            // eight bits per byte, msb first
            ph_r <= ph_r + 2'd1;
            case (ph_r)
            2'd0: sda_lo_r <= (dir_r && stage_r == 2'd2) ? 1'b0 : !sh_r[7];
            2'd1: scl_lo_r <= 1'b0;
            2'd2: sh_r <= {sh_r[6:0], sda_s_r};
            default: begin
               scl_lo_r <= 1'b1;
               bit_r <= bit_r - 3'd1;
               if (bit_r == 3'd0) begin
                  st_r <= S_ACK;
               end
            end
            endcase
         end
         S_ACK: if (tick) begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
            2'd0: begin
               if (dir_r && stage_r == 2'd2) begin
                  // low acks all but the last byte
                  sda_lo_r <= (left_r != 8'd1);
               end else begin
                  sda_lo_r <= 1'b0;
               end
            end
            2'd1: scl_lo_r <= 1'b0;
            2'd2: begin
               if (!(dir_r && stage_r == 2'd2) && sda_s_r) begin
                  // not acknowledged: wrong address or device busy
                  nack_err_r <= 1'b1;
               end
               if (dir_r && stage_r == 2'd2) begin
                  rd_byte_r <= sh_r;
                  rd_push_r <= 1'b1;
               end
            end
            default: begin
               scl_lo_r <= 1'b1;
               st_r <= S_NEXT;
            end
            endcase
         end
         S_NEXT: begin
            ph_r <= 2'd0;
            if (nack_err_r) begin
               st_r <= S_STOP;
            end else if (stage_r == 2'd0 && !dir_r) begin
               sh_r <= ptr_r;   // pointer byte
               stage_r <= 2'd1; bit_r <= 3'd7; st_r <= S_BIT;
            end else if (stage_r == 2'd1 && mode_r == 2'd1) begin
               dir_r <= `DIR_READ;   // repeated start, no stop
               st_r <= S_RSTART;
            end else begin
               if (stage_r == 2'd2) begin
                  left_r <= left_r - 8'd1;   // device pointer moves too
               end
               stage_r <= 2'd2;
               st_r <= S_FETCH;
            end
         end
         S_FETCH: begin
            bit_r <= 3'd7;
            if (left_r == 8'd0) begin
               st_r <= S_STOP;
            end else if (dir_r) begin
               // wait for fifo room so a read byte is never dropped
               if (rdf_ready) begin
                  st_r <= S_BIT;
               end
            end else if (wr_valid) begin
               sh_r <= wr_data;
               st_r <= S_BIT;
            end
         end
         S_STOP: if (tick) begin
            // sda rises while scl is high
            ph_r <= ph_r + 2'd1;
            case (ph_r)
            2'd0: sda_lo_r <= 1'b1;
            2'd1: scl_lo_r <= 1'b0;
            2'd2: sda_lo_r <= 1'b0;
            default: begin
               // busy drops with the state so cmd_ready never overlaps busy
               st_r   <= S_IDLE;
               busy_r <= 1'b0;
            end
            endcase
         end
         default: begin
            st_r   <= S_IDLE;
            busy_r <= 1'b0;
         end
         endcase
         // abort to a stop once the transaction limit is reached
         if (st_r != S_IDLE && st_r != S_STOP && tmo_r >= LIMIT_CYC - 1) begin
            timeout_r <= 1'b1;
            ph_r <= 2'd0;
            st_r <= S_STOP;
         end
      end
   end
endmodule // rtc_i2c_host

/* verilog/rtc_host_consts.vh */
// constants for the two-wire host controller of the clock chip
// assumes inclusion by bare name from the design files
`ifndef RTC_HOST_CONSTS_VH
`define RTC_HOST_CONSTS_VH
`define SLAVE_ADDR      7'h32
`define DIR_WRITE       1'b0
`define DIR_READ        1'b1
`define CLK_HZ          100000000
`define SCL_HZ          100000
`define XFER_LIMIT_MS   950
`define XFER_LIMIT_CYC  ((`CLK_HZ / 1000) * `XFER_LIMIT_MS)
`endif

/* verilog/byte_fifo.v */
// small synchronous fifo of flip-flops
// assumes one clock and an active-low synchronous reset
`timescale 1ns/1ps
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             rst_b,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   // flush
   input  wire             flush
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk_sys) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b || flush) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // byte_fifo

/* tb/rtc_i2c_host_sva.sv */
// port checker for the two-wire host controller
// assumes a bind onto rtc_i2c_host; one clock domain
`timescale 1ns/1ps
module rtc_i2c_host_chk #(
   parameter int CLK_DIV   = 4,
   parameter int LIMIT_CYC = 20000
) (
   // clock, reset, command
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       busy_r,
   // read stream and pins
   input wire logic       rd_valid,
   input wire logic       rd_ready,
   input wire logic [7:0] rd_data,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   localparam int HB   = 8 * CLK_DIV;
   localparam int MAXB = LIMIT_CYC + 64 * CLK_DIV;
   int busy_cyc_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ----------
   // assertions
   // ----------
   always @(posedge clk_sys) busy_cyc_r <= (!rst_b || !busy_r) ? 0 : busy_cyc_r + 1;
   idle_lines_a: assert property (!busy_r && !$past(busy_r) |-> !scl_oe && !sda_oe)
      else $error("bus line pulled while idle");
   open_drain_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   clock_in_xfer_a: assert property (scl_oe |-> busy_r)
      else $error("clock pulled outside a transaction");
   start_clock_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:HB] scl_oe)
      else $error("no clock after start");
   stop_ends_a: assert property ($fell(sda_oe) && !scl_oe |-> ##[0:HB] !busy_r)
      else $error("transaction open after stop");
   take_busy_a: assert property (cmd_valid && cmd_ready |=> busy_r && !cmd_ready)
      else $error("command taken without transaction");
   busy_refuse_a: assert property (busy_r |-> !cmd_ready)
      else $error("command accepted while busy");
   xfer_limit_a: assert property (busy_r |-> busy_cyc_r < MAXB)
      else $error("transaction too long");
   rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read byte dropped");
endmodule // rtc_i2c_host_chk
bind rtc_i2c_host rtc_i2c_host_chk #(.CLK_DIV(CLK_DIV), .LIMIT_CYC(LIMIT_CYC)) i_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .busy_r(busy_r), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

/* tb/rtc_slave_model.sv */
// behavioural clock chip, slave side of the two-wire bus
// assumes both lines resolved with pull-ups outside; 256 registers
`timescale 1ns/1ps
module rtc_slave_model (
   // bus
   input  wire        scl,
   input  wire        sda,
   output reg         scl_low,
   output reg         sda_low,
   // knobs
   input  wire [6:0]  own_addr,
   input  wire [31:0] stretch_ns
);
   reg [7:0] mem [0:255];
   reg [7:0] ptr, sh, tx;
   reg       rd, stall;
   integer   st, bitc, i;
   initial begin
      {scl_low, sda_low, ptr, rd} = 0;
      st = 0;
      bitc = 0;
      for (i = 0; i < 256; i = i + 1) mem[i] = i;
   end
   always @(negedge sda) if (scl === 1'b1) begin
      st = 1;
      bitc = 0;
   end
   always @(posedge sda) if (scl === 1'b1) st = 0;
   always @(posedge scl) if (st != 0) begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else if (st == 4 && sda) st = 0;
      bitc = bitc + 1;
   end
   always @(negedge scl) if (st != 0) begin
      stall = 0;
      if (bitc == 8 && st != 4) begin
         if (st == 1 && sh[7:1] != own_addr) st = 0;
         else begin
            if (st == 1) rd = sh[0];
            if (st == 2) ptr = sh;
            if (st == 3) mem[ptr] = sh;
            if (st == 3) ptr = ptr + 1;
            sda_low = 1;
         end
      end else if (bitc == 8) sda_low = 0;
      else if (bitc == 9) begin
         bitc = 0;
         sda_low = 0;
         if (st == 1) st = rd ? 4 : 2;
         else if (st == 2) st = 3;
         if (st == 4) tx = mem[ptr];
         if (st == 4) ptr = ptr + 1;
         stall = (stretch_ns != 0);
      end
      if (st == 4 && bitc < 8) sda_low = !tx[7 - bitc];
      if (st == 0) sda_low = 0;
      // slow answer: data is set before scl is let go, so no false start
      if (stall) begin
         scl_low = 1;
         #(stretch_ns) scl_low = 0;
      end
   end
endmodule // rtc_slave_model

/* tb/tb_rtc_i2c_host.sv */
// bench of the two-wire host against the behavioural clock chip
// assumes the slave model and the bound checker are compiled first
`timescale 1ns/1ps
`include "rtc_host_consts.vh"
module tb_rtc_i2c_host;
   logic        clk_sys, rst_b, cmd_valid, wr_valid, rd_ready;
   logic [1:0]  cmd_mode;
   logic [7:0]  cmd_ptr, cmd_len, wr_data;
   logic [6:0]  own_addr;
   logic [31:0] stretch;
   wire         cmd_ready, wr_ready, rd_valid, busy_r, nack_err_r, timeout_r;
   wire         scl_out, scl_oe, sda_out, sda_oe, m_scl, m_sda;
   wire  [7:0]  rd_data;
   wire         scl_w = !(scl_oe | m_scl);
   wire         sda_w = !(sda_oe | m_sda);
   int          err_count, checked, ref_ptr, ref_mem[256], rcount, seed, k, p, n;
   logic [7:0]  wq[$], eq[$];
   rtc_i2c_host #(.CLK_DIV(4), .LIMIT_CYC(20000), .FIFO_DEP(16)) i_rtc_i2c_host (
      .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_mode(cmd_mode), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .busy_r(busy_r), .nack_err_r(nack_err_r), .timeout_r(timeout_r),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe));
   rtc_slave_model i_rtc_slave_model (.scl(scl_w), .sda(sda_w), .scl_low(m_scl),
      .sda_low(m_sda), .own_addr(own_addr), .stretch_ns(stretch));
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // streams: feed write bytes, compare read bytes in order
   always @(posedge clk_sys) begin
      if (rd_valid === 1'b1 && rd_ready) rcount++;
      if (rd_valid === 1'b1 && rd_ready) chk(rd_data, eq.size() ? eq.pop_front() : 8'hxx);
      if (wr_valid && wr_ready === 1'b1) void'(wq.pop_front());
      #1 wr_valid = wq.size() != 0;
      wr_data = wq.size() ? wq[0] : 8'h00;
   end
   task automatic run(input logic [1:0] m, input logic [7:0] pt, input logic [7:0] len);
      int t;
      t = 0;
      if (m == 2'h2) pt = ref_ptr[7:0];
      for (int i = 0; i < len; i++) begin
         if (m == 2'h0) wq.push_back(8'($urandom));
         if (m == 2'h0) ref_mem[(pt + i) % 256] = wq[$];
         else eq.push_back(8'(ref_mem[(pt + i) % 256]));
      end
      {cmd_mode, cmd_ptr, cmd_len, cmd_valid} = {m, pt, len, 1'b1};
      do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++t < 1000);
      #1 cmd_valid = 0;
      repeat (3) @(posedge clk_sys);
      while (busy_r !== 1'b0 && ++t < 40000) @(posedge clk_sys);
      #1 if (t >= 40000) err_count++;
      if (own_addr == `SLAVE_ADDR) ref_ptr = (pt + len) % 256;
      if (rd_ready) chk(eq.size(), 8'h00);
   endtask
   initial begin
      {rst_b, cmd_valid, cmd_mode, cmd_ptr, cmd_len, wr_valid, wr_data} = 0;
      {err_count, checked, rcount, ref_ptr, stretch} = 0;
      rd_ready = 1;
      own_addr = `SLAVE_ADDR;
      seed = $urandom(32'hba15);
      for (int i = 0; i < 256; i++) ref_mem[i] = i;
      repeat (3) @(posedge clk_sys);
      #1 rst_b = 1;
      chk(cmd_ready, 8'h01);
      chk(scl_oe | sda_oe, 8'h00);
      for (k = 0; k < 3; k++) begin
         stretch = (k == 1) ? 300 : 0;
         p = $urandom_range(8'hef);
         n = $urandom_range(6, 1);
         run(2'h0, p[7:0], n[7:0]);
         run(2'h1, p[7:0], n[7:0]);
         run(2'h2, 8'h00, 8'h03);
         chk(nack_err_r, 8'h00);
      end
      own_addr = `SLAVE_ADDR ^ 7'h01;
      run(2'h0, 8'h05, 8'h00);
      chk(nack_err_r, 8'h01);
      own_addr = `SLAVE_ADDR;
      run(2'h2, 8'h00, 8'h02);
      chk(nack_err_r, 8'h00);
      // stalled reader fills the fifo until the limit aborts the read
      rd_ready = 0;
      rcount = 0;
      run(2'h1, 8'h10, 8'h28);
      chk(timeout_r, 8'h01);
      rd_ready = 1;
      repeat (40) @(posedge clk_sys);
      #1 chk(rcount[7:0], 8'h10);
      end_sim;
   end
   initial begin
      #900000;
      err_count++;
      end_sim;
   end
endmodule // tb_rtc_i2c_host
